// ==== rtcp_i2c_port.v ====
// Function
// - Temperature is a ten-bit signed code, quarter degree per step.
// - Integer byte at 11h; fraction in 12h bits 7:6, rest zero.
// - Reset loads zero degrees and starts a conversion at once.
// - Convert each second on main power, each ten seconds on backup.
// - Conversion completion refreshes temperature; serial writes to it ignored.
// - Alarm match sets that alarm's flag.
// - Interrupt asserts only when alarm enable and select bit are one.
// - Alarm matches are evaluated only on the once-per-second update.
// - Respond only to address byte D0h write or D1h read.
// - Wrong address: stay silent until the next START.
// - SDA changes while SCL low; device samples on SCL rise.
// - Read bits are driven at the falling edge before their pulse.
// - Receiver drives the ninth bit: zero acknowledges, one refuses.
// - Bytes travel MSB first, eight bits plus acknowledge.
// - Master refuses the last read byte; device then releases SDA.
// - First byte after write address loads the address counter.
// - Write bytes stored at successive locations; a byte that meets the eight-entry queue full is refused.
// - A read starts at the current address counter value.
// - Write address, register, repeated START, read address reads register.
// - Each master acknowledge makes the device send the next byte.
// - Device never holds SCL low.
// - Alarm flags clear only by writing zero; writing one keeps them.
`include "rtcp_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module rtcp_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = `RTCP_FIFO_DEPTH,
  parameter AW    = `RTCP_FIFO_AW
) (
  // Clock and reset
  input  wire             i_mclk,
  input  wire             i_reset,
  // Fill side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // Drain side
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wp_ff;
  reg [AW:0]      rp_ff;
  wire            push;
  wire            pop;

  assign o_in_ready  = (wp_ff - rp_ff) != DEPTH[AW:0];
  assign o_out_valid = wp_ff != rp_ff;
  assign o_out_data  = mem[rp_ff[AW-1:0]];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_mclk) begin
    if (push) begin
      mem[wp_ff[AW-1:0]] <= i_in_data;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      wp_ff <= {(AW+1){1'b0}};
      rp_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end
endmodule

module rtcp_i2c_port (
  // Clock and reset
  input  wire       i_mclk,
  input  wire       i_reset,
  // Serial bus pins
  input  wire       i_scl,
  input  wire       i_sda,
  output wire       o_sda,
  output wire       o_sda_oe,
  // Timebase and alarm inputs
  input  wire       i_second_tick,
  input  wire       i_alarm_one_match,
  input  wire       i_alarm_two_match,
  input  wire       i_wave_1hz,
  input  wire       i_on_backup,
  // Temperature sensor
  output wire       o_temp_start,
  input  wire       i_temp_done,
  input  wire [9:0] i_temp_code,
  // Interrupt or square wave, open drain
  output wire       o_irq_square_wave_out,
  output wire       o_irq_square_wave_oe
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACKA = 3'd2;
  localparam ST_WRX  = 3'd3;
  localparam ST_ACKW = 3'd4;
  localparam ST_RD   = 3'd5;
  localparam ST_RACK = 3'd6;
  localparam ST_IGN  = 3'd7;

  reg  [2:0]  scl_sync_ff;
  reg  [2:0]  sda_sync_ff;
  reg  [2:0]  state_ff;
  reg  [3:0]  cnt_ff;
  reg  [7:0]  sh_ff;
  reg  [7:0]  tx_ff;
  reg         oe_ff;
  reg         rw_ff;
  reg         first_ff;
  reg         mack_ff;
  reg  [4:0]  ptr_ff;
  reg  [7:0]  mem [0:18];
  reg  [7:0]  temp_hi_ff;
  reg  [1:0]  temp_lo_ff;
  reg         conv_ff;
  reg         sel_ff;
  reg         alarm_two_irq_enable_ff;
  reg         alarm_one_irq_enable_ff;
  reg         busy_ff;
  reg         alarm_one_flag_ff;
  reg         alarm_two_flag_ff;
  reg         pend_ff;
  reg         start_ff;
  reg  [3:0]  secs_ff;
  reg         push_ff;
  reg  [12:0] push_data_ff;
  reg         acc_ff;
  wire        scl;
  wire        sda;
  wire        scl_rise;
  wire        scl_fall;
  wire        bus_start;
  wire        bus_stop;
  wire        f_ready;
  wire        f_valid;
  wire [12:0] f_data;
  wire        w_stat;
  wire        w_ctrl;
  wire        drain;
  wire [7:0]  rd_byte;
  integer     i;

  // Second flop of each synchroniser onward
  assign scl       = scl_sync_ff[1];
  assign sda       = sda_sync_ff[1];
  assign scl_rise  = scl & ~scl_sync_ff[2];
  assign scl_fall  = ~scl & scl_sync_ff[2];
  assign bus_start = scl & scl_sync_ff[2] & ~sda & sda_sync_ff[2];
  assign bus_stop  = scl & scl_sync_ff[2] & sda & ~sda_sync_ff[2];
  assign o_sda     = 1'b0;
  assign o_sda_oe  = oe_ff;

  function [4:0] next_ptr;
    input [4:0] p;
    begin
      next_ptr = (p >= `RTCP_ADDR_LAST) ? 5'h00 : p + 5'h01;
    end
  endfunction

  function [7:0] reg_read;
    input [4:0] a;
    begin
      case (a)
        `RTCP_ADDR_CTRL: begin
          reg_read = {mem[a][7:6], conv_ff, mem[a][4:3], sel_ff, alarm_two_irq_enable_ff,
                      alarm_one_irq_enable_ff};
        end
        `RTCP_ADDR_STAT: begin
          reg_read = {mem[a][7:3], busy_ff, alarm_two_flag_ff,
                      alarm_one_flag_ff};
        end
        `RTCP_ADDR_TEMP_HI: reg_read = temp_hi_ff;
        `RTCP_ADDR_TEMP_LO: reg_read = {temp_lo_ff, 6'h00};
        default: begin
          reg_read = (a > `RTCP_ADDR_LAST) ? 8'h00 : mem[a];
        end
      endcase
    end
  endfunction

  assign rd_byte = reg_read(ptr_ff);

  always @(posedge i_mclk) begin
    if (i_reset) begin
      scl_sync_ff <= 3'b111;
      sda_sync_ff <= 3'b111;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], i_scl};
      sda_sync_ff <= {sda_sync_ff[1:0], i_sda};
    end
  end

  // Bus protocol engine
  always @(posedge i_mclk) begin
    if (i_reset) begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= 4'h0;
      sh_ff        <= 8'h00;
      tx_ff        <= 8'h00;
      oe_ff        <= 1'b0;
      rw_ff        <= 1'b0;
      first_ff     <= 1'b0;
      mack_ff      <= 1'b0;
      ptr_ff       <= 5'h00;
      push_ff      <= 1'b0;
      push_data_ff <= 13'h0000;
      acc_ff       <= 1'b0;
    end else begin
      push_ff <= 1'b0;
      acc_ff  <= 1'b0;
      // START or STOP abandons any byte
      if (bus_start) begin
        state_ff <= ST_ADDR;
        cnt_ff   <= 4'h0;
        oe_ff    <= 1'b0;
      end else if (bus_stop) begin
        state_ff <= ST_IDLE;
        oe_ff    <= 1'b0;
      end else begin
        case (state_ff)
          ST_ADDR, ST_WRX: begin
            // Sample on SCL rise, MSB first
            if (scl_rise && cnt_ff != 4'h8) begin
              sh_ff  <= {sh_ff[6:0], sda};
              cnt_ff <= cnt_ff + 4'h1;
            end
            if (scl_fall && cnt_ff == 4'h8) begin
              if (state_ff == ST_ADDR) begin
                if (sh_ff[7:1] == `RTCP_SLAVE_ADDR) begin
                  oe_ff    <= 1'b1;
                  rw_ff    <= sh_ff[0];
                  first_ff <= ~sh_ff[0];
                  acc_ff   <= 1'b1;
                  state_ff <= ST_ACKA;
                end else begin
                  state_ff <= ST_IGN;
                end
              end else begin
                state_ff <= ST_ACKW;
                if (first_ff) begin
                  ptr_ff <= sh_ff[4:0];
                  oe_ff  <= 1'b1;
                end else if (f_ready) begin
                  push_ff      <= 1'b1;
                  push_data_ff <= {ptr_ff, sh_ff};
                  ptr_ff       <= next_ptr(ptr_ff);
                  oe_ff        <= 1'b1;
                end
              end
            end
          end
          ST_ACKA: begin
            if (scl_fall) begin
              cnt_ff <= 4'h0;
              if (rw_ff) begin
                tx_ff    <= {rd_byte[6:0], 1'b0};
                oe_ff    <= ~rd_byte[7];
                ptr_ff   <= next_ptr(ptr_ff);
                state_ff <= ST_RD;
              end else begin
                oe_ff    <= 1'b0;
                state_ff <= ST_WRX;
              end
            end
          end
          ST_ACKW: begin
            if (scl_fall) begin
              oe_ff    <= 1'b0;
              first_ff <= 1'b0;
              cnt_ff   <= 4'h0;
              state_ff <= ST_WRX;
            end
          end
          ST_RD: begin
            // Next bit driven on SCL fall
            if (scl_fall) begin
              if (cnt_ff == 4'h7) begin
                oe_ff    <= 1'b0;
                state_ff <= ST_RACK;
              end else begin
                oe_ff  <= ~tx_ff[7];
                tx_ff  <= {tx_ff[6:0], 1'b0};
                cnt_ff <= cnt_ff + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_ff <= ~sda;
            end
            if (scl_fall) begin
              cnt_ff <= 4'h0;
              if (mack_ff) begin
                tx_ff    <= {rd_byte[6:0], 1'b0};
                oe_ff    <= ~rd_byte[7];
                ptr_ff   <= next_ptr(ptr_ff);
                state_ff <= ST_RD;
              end else begin
                oe_ff    <= 1'b0;
                state_ff <= ST_IGN;
              end
            end
          end
          default: begin
            oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  rtcp_fifo #(
    .WIDTH (13),
    .DEPTH (`RTCP_FIFO_DEPTH),
    .AW    (`RTCP_FIFO_AW)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_in_valid  (push_ff),
    .o_in_ready  (f_ready),
    .i_in_data   (push_data_ff),
    .o_out_valid (f_valid),
    .i_out_ready (drain),
    .o_out_data  (f_data)
  );

  // Sensor completion owns the register port for that cycle
  assign drain  = ~i_temp_done;
  assign w_ctrl = f_valid & drain & (f_data[12:8] == `RTCP_ADDR_CTRL);
  assign w_stat = f_valid & drain & (f_data[12:8] == `RTCP_ADDR_STAT);

  always @(posedge i_mclk) begin
    if (i_reset) begin
      for (i = 0; i < 19; i = i + 1) begin
        mem[i] <= `RTCP_MEM_RST;
      end
    end else if (f_valid && drain && f_data[12:8] != `RTCP_ADDR_TEMP_HI &&
                 f_data[12:8] != `RTCP_ADDR_TEMP_LO &&
                 f_data[12:8] <= `RTCP_ADDR_LAST) begin
      mem[f_data[12:8]] <= f_data[7:0];
    end
  end

  // Control, status and conversion scheduling
  always @(posedge i_mclk) begin
    if (i_reset) begin
      temp_hi_ff        <= `RTCP_TEMP_RST;
      temp_lo_ff        <= 2'b00;
      pend_ff           <= 1'b1;
      conv_ff           <= 1'b0;
      sel_ff            <= 1'b1;
      alarm_two_irq_enable_ff           <= 1'b0;
      alarm_one_irq_enable_ff           <= 1'b0;
      busy_ff           <= 1'b0;
      start_ff          <= 1'b0;
      secs_ff           <= 4'h0;
      alarm_one_flag_ff <= 1'b0;
      alarm_two_flag_ff <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      if (w_ctrl) begin
        sel_ff  <= f_data[`RTCP_CTRL_SEL];
        alarm_two_irq_enable_ff <= f_data[`RTCP_CTRL_ALARM_TWO_IRQ_ENABLE];
        alarm_one_irq_enable_ff <= f_data[`RTCP_CTRL_ALARM_ONE_IRQ_ENABLE];
      end
      if (i_second_tick) begin
        if (!i_on_backup) begin
          pend_ff <= 1'b1;
          secs_ff <= 4'h0;
        end else if (secs_ff == `RTCP_BACKUP_SECS - 4'h1) begin
          pend_ff <= 1'b1;
          secs_ff <= 4'h0;
        end else begin
          secs_ff <= secs_ff + 4'h1;
        end
      end
      if (acc_ff && i_on_backup) begin
        pend_ff <= 1'b1;
      end
      if (w_ctrl && f_data[`RTCP_CTRL_CONV]) begin
        conv_ff <= 1'b1;
        pend_ff <= 1'b1;
      end
      if (pend_ff && !busy_ff) begin
        start_ff <= 1'b1;
        busy_ff  <= 1'b1;
        pend_ff  <= 1'b0;
      end
      if (i_temp_done && busy_ff) begin
        temp_hi_ff <= i_temp_code[9:2];
        temp_lo_ff <= i_temp_code[1:0];
        busy_ff    <= 1'b0;
        conv_ff    <= 1'b0;
      end
      // Flags clear only by zero; set wins
      if (w_stat && !f_data[`RTCP_STAT_A1F]) begin
        alarm_one_flag_ff <= 1'b0;
      end
      if (w_stat && !f_data[`RTCP_STAT_A2F]) begin
        alarm_two_flag_ff <= 1'b0;
      end
      if (i_second_tick && i_alarm_one_match) begin
        alarm_one_flag_ff <= 1'b1;
      end
      if (i_second_tick && i_alarm_two_match) begin
        alarm_two_flag_ff <= 1'b1;
      end
    end
  end

  assign o_temp_start = start_ff;

  // Gated alarm interrupt or square wave
  assign o_irq_square_wave_out = 1'b0;
  assign o_irq_square_wave_oe  = sel_ff ?
      ((alarm_one_flag_ff & alarm_one_irq_enable_ff) | (alarm_two_flag_ff & alarm_two_irq_enable_ff)) :
      ~i_wave_1hz;
endmodule

`default_nettype wire

// ==== rtcp_defs.vh ====
`ifndef RTCP_DEFS_VH
`define RTCP_DEFS_VH
`define RTCP_SLAVE_ADDR   7'h68
`define RTCP_ADDR_LAST    5'h12
`define RTCP_ADDR_CTRL    5'h0e
`define RTCP_ADDR_STAT    5'h0f
`define RTCP_ADDR_TEMP_HI 5'h11
`define RTCP_ADDR_TEMP_LO 5'h12
`define RTCP_CTRL_CONV    5
`define RTCP_CTRL_SEL     2
`define RTCP_CTRL_ALARM_TWO_IRQ_ENABLE    1
`define RTCP_CTRL_ALARM_ONE_IRQ_ENABLE    0
`define RTCP_STAT_BUSY    2
`define RTCP_STAT_A2F     1
`define RTCP_STAT_A1F     0
`define RTCP_TEMP_RST     8'h00
`define RTCP_MEM_RST      8'h00
`define RTCP_BACKUP_SECS  4'ha
`define RTCP_FIFO_DEPTH   8
`define RTCP_FIFO_AW      3
`endif

// ==== rtcp_i2c_port_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtcp_i2c_port_monitor (
  // Clock and reset
  input wire logic       i_mclk,
  input wire logic       i_reset,
  // Serial bus pins
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda,
  input wire logic       o_sda_oe,
  // Timebase and alarms
  input wire logic       i_second_tick,
  input wire logic       i_alarm_one_match,
  input wire logic       i_alarm_two_match,
  input wire logic       i_wave_1hz,
  input wire logic       i_on_backup,
  // Temperature sensor
  input wire logic       o_temp_start,
  input wire logic       i_temp_done,
  input wire logic [9:0] i_temp_code,
  // Interrupt pin
  input wire logic       o_irq_square_wave_out,
  input wire logic       o_irq_square_wave_oe
);
  logic [3:0] low_cnt_ff;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  // Cycles since the serial clock went low, saturating
  always @(posedge i_mclk) begin
    if (i_scl) begin
      low_cnt_ff <= 4'h0;
    end else if (low_cnt_ff != 4'hf) begin
      low_cnt_ff <= low_cnt_ff + 4'h1;
    end
  end

  sda_open_drain_a: assert property (o_sda == 1'b0)
    else $error("data pin value not zero");
  irq_open_drain_a: assert property (o_irq_square_wave_out == 1'b0)
    else $error("interrupt pin value not zero");
  sda_low_phase_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data drive changed while clock high");
  sda_after_fall_a: assert property (
    $changed(o_sda_oe) |-> low_cnt_ff inside {[4'h1:4'h8]})
    else $error("data drive not changed just after clock fall");
  conv_pulse_a: assert property (o_temp_start |=> !o_temp_start)
    else $error("conversion start longer than one cycle");
  reset_conv_a: assert property ($fell(i_reset) |-> ##[0:3] o_temp_start)
    else $error("no conversion after reset");
  main_tick_conv_a: assert property (
    i_second_tick && !i_on_backup |-> ##[1:4] o_temp_start)
    else $error("no conversion on main power tick");
  irq_on_tick_a: assert property (
    $rose(o_irq_square_wave_oe) && !$changed(i_wave_1hz)
      |-> $past(i_second_tick))
    else $error("interrupt rose away from a tick");

  cover property ($rose(o_sda_oe));
  cover property ($rose(o_irq_square_wave_oe));
  cover property (o_temp_start && i_on_backup);
endmodule
`default_nettype wire

// ==== rtcp_i2c_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtcp_i2c_master (
  // Clock and wire level
  input  wire logic i_mclk,
  input  wire logic i_sda,
  // Bus drive, oe high pulls data low
  output var logic  o_scl,
  output var logic  o_sda_oe
);
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic q(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic start;
    q(4);
    o_sda_oe <= 1'b0;
    q(4);
    o_scl <= 1'b1;
    q(8);
    o_sda_oe <= 1'b1;
    q(8);
    o_scl <= 1'b0;
  endtask

  task automatic stop;
    q(4);
    o_sda_oe <= 1'b1;
    q(4);
    o_scl <= 1'b1;
    q(8);
    o_sda_oe <= 1'b0;
    q(8);
  endtask

  // data moves mid low phase, sampled at end of high
  task automatic xbit(input logic b, output logic r);
    q(4);
    o_sda_oe <= ~b;
    q(4);
    o_scl <= 1'b1;
    q(8);
    r = i_sda;
    o_scl <= 1'b0;
  endtask

  // msb first, ninth bit from receiver
  task automatic xbyte(input logic [7:0] d, input logic ab,
                       output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
    xbit(ab, a);
  endtask
endmodule
`default_nettype wire

// ==== rtcp_i2c_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtcp_i2c_port_tb;
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        tick = 1'b0;
  logic        al1  = 1'b0;
  logic        al2  = 1'b0;
  logic        wave = 1'b0;
  logic        bkp  = 1'b0;
  logic        done = 1'b0;
  logic [9:0]  code = 10'h000;
  logic        scl;
  logic        m_oe;
  logic        ak;
  logic [7:0]  r8;
  logic [7:0]  rb [0:15];
  logic [7:0]  fq [$];
  logic [25:0] trow [0:3] = '{{10'h065, 8'h19, 8'h40},
    {10'h3ff, 8'hff, 8'hc0}, {10'h200, 8'h80, 8'h00},
    {10'h1fe, 8'h7f, 8'h80}};
  logic [7:0]  bad [0:2] = '{8'ha0, 8'hd2, 8'h51};
  int          n_errors = 0;
  int          num_checks = 0;
  int          nstart = 0;
  int          b;
  wire         sda_v;
  wire         sda_oe;
  wire         irq_oe;
  wire         tstart;
  wire         sda = ~m_oe & (sda_oe ? sda_v : 1'b1);

  initial begin
    forever #5 mclk = ~mclk;
  end

  rtcp_i2c_port uut (
    .i_mclk(mclk), .i_reset(rst), .i_scl(scl), .i_sda(sda),
    .o_sda(sda_v), .o_sda_oe(sda_oe), .i_second_tick(tick),
    .i_alarm_one_match(al1), .i_alarm_two_match(al2),
    .i_wave_1hz(wave), .i_on_backup(bkp), .o_temp_start(tstart),
    .i_temp_done(done), .i_temp_code(code),
    .o_irq_square_wave_out(), .o_irq_square_wave_oe(irq_oe)
  );
  rtcp_i2c_master m (.i_mclk(mclk), .i_sda(sda), .o_scl(scl),
    .o_sda_oe(m_oe));

  always @(posedge mclk) if (tstart) nstart <= nstart + 1;

  task automatic chk(input string nm, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d[$],
                    output logic k);
    m.start;
    m.xbyte(8'hd0, 1'b1, r8, k);
    m.xbyte(a, 1'b1, r8, k);
    foreach (d[i]) m.xbyte(d[i], 1'b1, r8, k);
    m.stop;
  endtask

  task automatic rd(input logic set, input logic [7:0] a, input int n);
    m.start;
    if (set) begin
      m.xbyte(8'hd0, 1'b1, r8, ak);
      m.xbyte(a, 1'b1, r8, ak);
      m.start;
    end
    m.xbyte(8'hd1, 1'b1, r8, ak);
    // acknowledge all but the last byte
    for (int i = 0; i < n; i++) m.xbyte(8'hff, i == n - 1, rb[i], ak);
    m.stop;
  endtask

  task automatic pulse_done(input logic [9:0] c);
    code <= c;
    done <= 1'b1;
    @(posedge mclk);
    done <= 1'b0;
  endtask

  task automatic tick_n(input int n);
    repeat (n) begin
      @(posedge mclk);
      tick <= 1'b1;
      wave <= ~wave;
      @(posedge mclk);
      tick <= 1'b0;
      repeat (6) @(posedge mclk);
      pulse_done(code);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    end_of_test;
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("conv_at_reset", 8'(nstart), 8'h01);
    chk("pins_idle", {6'h00, sda_oe, irq_oe}, 8'h00);
    rd(1'b1, 8'h11, 2);
    chk("temp_hi_rst", rb[0], 8'h00);
    chk("temp_lo_rst", rb[1], 8'h00);
    rd(1'b1, 8'h0e, 1);
    chk("ctrl_rst", rb[0], 8'h04);
    pulse_done(10'h000);
    foreach (trow[i]) begin
      wr(8'h0e, '{8'h24}, ak);
      repeat (8) @(posedge mclk);
      pulse_done(trow[i][25:16]);
      rd(1'b1, 8'h11, 2);
      chk("temp_hi", rb[0], trow[i][15:8]);
      chk("temp_lo", rb[1], trow[i][7:0]);
    end
    chk("user_conv", 8'(nstart), 8'h05);
    wr(8'h11, '{8'h55, 8'h66}, ak);
    rd(1'b1, 8'h11, 2);
    chk("ro_hi", rb[0], 8'h7f);
    chk("ro_lo", rb[1], 8'h80);
    wr(8'h00, '{8'h11, 8'h22, 8'h33}, ak);
    chk("wr_ack", {7'h00, ak}, 8'h00);
    rd(1'b1, 8'h00, 2);
    chk("burst0", rb[0], 8'h11);
    chk("burst1", rb[1], 8'h22);
    rd(1'b0, 8'h00, 1);
    chk("plain_rd", rb[0], 8'h33);
    rd(1'b1, 8'h12, 2);
    chk("wrap", rb[1], 8'h11);
    foreach (bad[i]) begin
      m.start;
      m.xbyte(bad[i], 1'b1, r8, ak);
      chk("bad_addr", {7'h00, ak}, 8'h01);
      m.xbyte(8'h00, 1'b1, r8, ak);
      chk("ignored", {7'h00, ak}, 8'h01);
      m.stop;
    end
    m.start;
    repeat (3) m.xbit(1'b1, r8[0]);
    rd(1'b1, 8'h01, 1);
    chk("abort", rb[0], 8'h22);
    wr(8'h0e, '{8'h05}, ak);
    al1 <= 1'b1;
    al2 <= 1'b1;
    repeat (20) @(posedge mclk);
    chk("irq_no_tick", {7'h00, irq_oe}, 8'h00);
    tick_n(1);
    al1 <= 1'b0;
    al2 <= 1'b0;
    chk("irq_on", {7'h00, irq_oe}, 8'h01);
    rd(1'b1, 8'h0f, 1);
    chk("flags", rb[0] & 8'h03, 8'h03);
    wr(8'h0f, '{8'h03}, ak);
    chk("irq_keep", {7'h00, irq_oe}, 8'h01);
    wr(8'h0f, '{8'h02}, ak);
    chk("irq_off", {7'h00, irq_oe}, 8'h00);
    rd(1'b1, 8'h0f, 1);
    chk("flag_clr", rb[0] & 8'h03, 8'h02);
    wr(8'h0e, '{8'h02}, ak);
    chk("wave_hi", {7'h00, irq_oe}, 8'h00);
    wave <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("wave_lo", {7'h00, irq_oe}, 8'h01);
    wr(8'h0e, '{8'h04}, ak);
    chk("wave_off", {7'h00, irq_oe}, 8'h00);
    bkp <= 1'b1;
    b = nstart;
    tick_n(20);
    chk("bkp_conv", 8'(nstart - b), 8'h02);
    rd(1'b0, 8'h00, 1);
    pulse_done(code);
    chk("bkp_access", 8'(nstart - b), 8'h03);
    bkp <= 1'b0;
    b = nstart;
    tick_n(2);
    chk("main_conv", 8'(nstart - b), 8'h02);
    for (int i = 0; i < 9; i++) fq.push_back(8'h40 + 8'(i));
    @(posedge mclk);
    done <= 1'b1;
    wr(8'h00, fq, ak);
    done <= 1'b0;
    chk("fifo_full", {7'h00, ak}, 8'h01);
    rd(1'b1, 8'h00, 8);
    for (int i = 0; i < 8; i++) chk("fifo_data", rb[i], fq[i]);
    // Second reset in mid-run
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    b = nstart;
    repeat (6) @(posedge mclk);
    chk("conv_rerst", 8'(nstart - b), 8'h01);
    rd(1'b1, 8'h11, 2);
    chk("temp_hi_rerst", rb[0], 8'h00);
    chk("temp_lo_rerst", rb[1], 8'h00);
    end_of_test;
  end
endmodule

bind rtcp_i2c_port rtcp_i2c_port_monitor mon (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_second_tick(i_second_tick),
  .i_alarm_one_match(i_alarm_one_match),
  .i_alarm_two_match(i_alarm_two_match), .i_wave_1hz(i_wave_1hz),
  .i_on_backup(i_on_backup), .o_temp_start(o_temp_start),
  .i_temp_done(i_temp_done), .i_temp_code(i_temp_code),
  .o_irq_square_wave_out(o_irq_square_wave_out),
  .o_irq_square_wave_oe(o_irq_square_wave_oe)
);
`default_nettype wire
